// ==== logic/calam_pkg.sv ====
// Package: offsets, field layouts, reset values and types of the calendar and alarm match block
package calam_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] CALAM_OFF_MONTH_OF_YEAR     = 8'h0d;
  localparam logic [7:0] CALAM_OFF_YEAR_IN_CENTURY   = 8'h0e;
  localparam logic [7:0] CALAM_OFF_ALARM_SECOND      = 8'h10;
  localparam logic [7:0] CALAM_OFF_ALARM_MINUTE      = 8'h11;
  localparam logic [7:0] CALAM_OFF_ALARM_HOUR        = 8'h12;
  localparam logic [7:0] CALAM_OFF_ALARM_DAY         = 8'h13;
  localparam logic [7:0] CALAM_OFF_ALARM_WEEKDAY     = 8'h14;
  localparam logic [7:0] CALAM_OFF_ALARM_MONTH       = 8'h15;
  localparam logic [7:0] CALAM_OFF_ALARM_YEAR        = 8'h16;

  // ----------------------------------------------------------------
  // Field layouts
  // ----------------------------------------------------------------
  localparam int         CALAM_MONTH_W               = 5;
  localparam int         CALAM_YEAR_W                = 7;
  localparam int         CALAM_ALARM_FIELDS          = 7;
  localparam int         CALAM_ALARM_EN_BIT          = 7;
  localparam logic [7:0] CALAM_MONTH_MASK            = 8'h1f;
  localparam logic [7:0] CALAM_YEAR_MASK             = 8'h7f;
  // Value bits compared per alarm field: sec, min, hour, day, weekday, month, year
  localparam logic [CALAM_ALARM_FIELDS-1:0][6:0] CALAM_FIELD_MASK =
    {7'h7f, 7'h1f, 7'h07, 7'h3f, 7'h3f, 7'h7f, 7'h7f};

  // ----------------------------------------------------------------
  // Reset values and calendar constants
  // ----------------------------------------------------------------
  localparam logic [4:0] CALAM_MONTH_RESET           = 5'h01;
  localparam logic [6:0] CALAM_YEAR_RESET            = 7'h00;
  localparam logic [7:0] CALAM_ALARM_RESET           = 8'h00;
  localparam logic [7:0] CALAM_RDATA_RESET           = 8'h00;
  localparam logic [4:0] CALAM_MONTH_FIRST           = 5'h01;
  localparam logic [4:0] CALAM_MONTH_FEB             = 5'h02;
  localparam logic [4:0] CALAM_MONTH_LAST            = 5'h12;
  localparam logic [6:0] CALAM_YEAR_LAST             = 7'h79;
  localparam logic [5:0] CALAM_DAYS_31               = 6'h31;
  localparam logic [5:0] CALAM_DAYS_30               = 6'h30;
  localparam logic [5:0] CALAM_DAYS_29               = 6'h29;
  localparam logic [5:0] CALAM_DAYS_28               = 6'h28;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [4:0]                          month;
    logic [6:0]                          year;
    logic [CALAM_ALARM_FIELDS-1:0][7:0]  alarm;
    logic                                match_prev;
    logic                                flag;
    logic                                int_n;
    logic [7:0]                          rdata;
    logic [5:0]                          month_len;
  } calam_state_s;

endpackage

// ==== logic/calam_calendar_alarm_match.sv ====
// Month and year calendar registers with the alarm page match logic
`timescale 1ns/1ps
module calam_calendar_alarm_match
  import calam_pkg::*;
(
  input  wire logic       CLOCK_IN,
  input  wire logic       RESET_IN,
  input  wire logic [7:0] REG_ADDR_IN,
  input  wire logic [7:0] REG_WDATA_IN,
  input  wire logic       REG_WRITE_IN,
  input  wire logic       REG_READ_IN,
  output logic      [7:0] REG_RDATA_OUT,
  input  wire logic [6:0] NOW_SECONDS_IN,
  input  wire logic [6:0] NOW_MINUTES_IN,
  input  wire logic [5:0] NOW_HOURS_IN,
  input  wire logic [5:0] NOW_DAY_IN,
  input  wire logic [2:0] NOW_WEEKDAY_IN,
  input  wire logic       MONTH_ADVANCE_IN,
  input  wire logic       ALARM_IRQ_ENABLE_IN,
  input  wire logic       ALARM_FLAG_CLEAR_IN,
  output logic            ALARM_MATCH_FLAG_OUT,
  output logic            INT_N_OUT,
  output logic      [5:0] MONTH_LENGTH_OUT
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Maps an offset to an alarm slot; returns CALAM_ALARM_FIELDS when not an alarm register
  function automatic logic [2:0] alarm_slot(input logic [7:0] addr);
    logic [7:0] rel;
    rel = addr - CALAM_OFF_ALARM_SECOND;
    if (addr >= CALAM_OFF_ALARM_SECOND && addr <= CALAM_OFF_ALARM_YEAR)
      alarm_slot = rel[2:0];
    else
      alarm_slot = 3'(CALAM_ALARM_FIELDS);
  endfunction

  // BCD leap test: tens even needs units 0/4/8, tens odd needs units 2/6
  function automatic logic is_leap(input logic [6:0] yr);
    logic [3:0] u;
    u = yr[3:0];
    if (yr[4] == 1'b0)
      is_leap = (u == 4'h0) || (u == 4'h4) || (u == 4'h8);
    else
      is_leap = (u == 4'h2) || (u == 4'h6);
  endfunction

  function automatic logic [6:0] bcd_inc(input logic [6:0] v);
    if (v[3:0] == 4'h9)
      bcd_inc = {3'(v[6:4] + 3'h1), 4'h0};
    else
      bcd_inc = {v[6:4], 4'(v[3:0] + 4'h1)};
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  calam_state_s                            st_reg;
  calam_state_s                            st_next;
  logic [CALAM_ALARM_FIELDS-1:0][6:0]      now_val;
  logic                                    full_match;
  logic                                    any_enabled;
  logic [2:0]                              wslot;
  logic [2:0]                              rslot;
  logic [6:0]                              month_inc;
  logic [CALAM_ALARM_FIELDS-1:0]           field_en;
  logic [CALAM_ALARM_FIELDS-1:0]           field_hit;

  // ----------------------------------------------------------------
  // Current time per alarm slot
  // ----------------------------------------------------------------
  // Month and year slots compare against this block's own registers
  assign now_val = {st_reg.year, {2'h0, st_reg.month}, {4'h0, NOW_WEEKDAY_IN},
                    {1'h0, NOW_DAY_IN}, {1'h0, NOW_HOURS_IN}, NOW_MINUTES_IN, NOW_SECONDS_IN};

  // ----------------------------------------------------------------
  // Per-field compare
  // ----------------------------------------------------------------
  // Unused value bits are masked, so a stray high bit cannot block a match
  generate
    for (genvar g = 0; g < CALAM_ALARM_FIELDS; g++)
    begin : g_field
      assign field_en[g]  = st_reg.alarm[g][CALAM_ALARM_EN_BIT];
      assign field_hit[g] = (st_reg.alarm[g][6:0] & CALAM_FIELD_MASK[g]) == (now_val[g] & CALAM_FIELD_MASK[g]);
    end
  endgenerate

  always_comb
  begin
    st_next     = st_reg;
    wslot       = alarm_slot(REG_ADDR_IN);
    rslot       = alarm_slot(REG_ADDR_IN);
    month_inc   = bcd_inc({2'h0, st_reg.month});

    // ----------------------------------------------------------------
    // Calendar
    // ----------------------------------------------------------------
    // Advance pulse comes from the day counter at the end of a month
    if (MONTH_ADVANCE_IN)
    begin
      if (st_reg.month == CALAM_MONTH_LAST)
      begin
        // December rolls into January of the next year; 79 wraps to 00
        st_next.month = CALAM_MONTH_FIRST;
        st_next.year  = (st_reg.year == CALAM_YEAR_LAST) ? CALAM_YEAR_RESET : bcd_inc(st_reg.year);
      end
      else
        st_next.month = month_inc[4:0];
    end

    // ----------------------------------------------------------------
    // Register write
    // ----------------------------------------------------------------
    // Software write wins over a same-cycle advance
    // Codes are stored as written, less bits above the month and year fields; an invalid BCD value is not caught here
    if (REG_WRITE_IN)
    begin
      if (REG_ADDR_IN == CALAM_OFF_MONTH_OF_YEAR)
        st_next.month = REG_WDATA_IN[4:0];
      else if (REG_ADDR_IN == CALAM_OFF_YEAR_IN_CENTURY)
        st_next.year = REG_WDATA_IN[6:0];
      else if (wslot != 3'(CALAM_ALARM_FIELDS))
        st_next.alarm[wslot] = REG_WDATA_IN;
    end

    // ----------------------------------------------------------------
    // Month length
    // ----------------------------------------------------------------
    // Follows the registered month and year, so it trails a change by one cycle
    // Thirty days: April, June, September and November
    if (st_reg.month == CALAM_MONTH_FEB)
      st_next.month_len = is_leap(st_reg.year) ? CALAM_DAYS_29 : CALAM_DAYS_28;
    else if (st_reg.month == 5'h04 || st_reg.month == 5'h06 ||
             st_reg.month == 5'h09 || st_reg.month == 5'h11)
      st_next.month_len = CALAM_DAYS_30;
    else
      st_next.month_len = CALAM_DAYS_31;

    // ----------------------------------------------------------------
    // Alarm compare
    // ----------------------------------------------------------------
    // A disabled field counts as matching, so it can neither block nor cause an alarm
    any_enabled = |field_en;
    full_match  = &(field_hit | ~field_en);
    // No enabled field means nothing to match, not a permanent match
    full_match  = full_match & any_enabled;

    // ----------------------------------------------------------------
    // Alarm flag and interrupt
    // ----------------------------------------------------------------
    st_next.match_prev = full_match;
    // Set on the entering edge only; set beats a same-cycle clear
    if (full_match && !st_reg.match_prev && ALARM_IRQ_ENABLE_IN)
      st_next.flag = 1'b1;
    else if (ALARM_FLAG_CLEAR_IN)
      st_next.flag = 1'b0;
    // Dropping the enable releases the pin but keeps the flag
    st_next.int_n = ~(st_next.flag & ALARM_IRQ_ENABLE_IN);

    // ----------------------------------------------------------------
    // Register read
    // ----------------------------------------------------------------
    // A read beside a same-cycle write returns the old value
    // Read data holds until the next read
    if (REG_READ_IN)
    begin
      if (REG_ADDR_IN == CALAM_OFF_MONTH_OF_YEAR)
        st_next.rdata = {3'h0, st_reg.month};
      else if (REG_ADDR_IN == CALAM_OFF_YEAR_IN_CENTURY)
        st_next.rdata = {1'h0, st_reg.year};
      else if (rslot != 3'(CALAM_ALARM_FIELDS))
        st_next.rdata = st_reg.alarm[rslot];
      else
        st_next.rdata = CALAM_RDATA_RESET;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Synchronous reset to January of year 00 with every alarm field off
  always_ff @(posedge CLOCK_IN)
  begin
    if (RESET_IN)
    begin
      st_reg.month      <= CALAM_MONTH_RESET;
      st_reg.year       <= CALAM_YEAR_RESET;
      st_reg.alarm      <= {CALAM_ALARM_FIELDS{CALAM_ALARM_RESET}};
      st_reg.match_prev <= 1'b0;
      st_reg.flag       <= 1'b0;
      st_reg.int_n      <= 1'b1;
      st_reg.rdata      <= CALAM_RDATA_RESET;
      st_reg.month_len  <= CALAM_DAYS_31;
    end
    else
      st_reg <= st_next;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Every output is a plain state flip-flop, so nothing glitches at the pins
  assign REG_RDATA_OUT        = st_reg.rdata;
  assign ALARM_MATCH_FLAG_OUT = st_reg.flag;
  assign INT_N_OUT            = st_reg.int_n;
  assign MONTH_LENGTH_OUT     = st_reg.month_len;

endmodule // calam_calendar_alarm_match

// ==== tb/calam_monitor.sv ====
// Port checker for the calendar and alarm match block
`timescale 1ns/1ps
module calam_monitor (
  input wire logic       CLOCK_IN,
  input wire logic       RESET_IN,
  input wire logic [7:0] REG_ADDR_IN,
  input wire logic       REG_READ_IN,
  input wire logic [7:0] REG_RDATA_OUT,
  input wire logic       ALARM_IRQ_ENABLE_IN,
  input wire logic       ALARM_FLAG_CLEAR_IN,
  input wire logic       ALARM_MATCH_FLAG_OUT,
  input wire logic       INT_N_OUT,
  input wire logic [5:0] MONTH_LENGTH_OUT
);
  default clocking @(posedge CLOCK_IN); endclocking
  default disable iff (RESET_IN);
  AST_SET_NEEDS_EN: assert property ($rose(ALARM_MATCH_FLAG_OUT) |-> $past(ALARM_IRQ_ENABLE_IN))
    else $error("flag set while irq enable low");
  AST_INT_ON_SET: assert property ($rose(ALARM_MATCH_FLAG_OUT) |-> !INT_N_OUT)
    else $error("interrupt not low with new flag");
  AST_INT_OFF_CLEAR: assert property ($fell(ALARM_MATCH_FLAG_OUT) |-> INT_N_OUT)
    else $error("interrupt still low after clear");
  AST_INT_NEEDS_FLAG: assert property (!INT_N_OUT |-> ALARM_MATCH_FLAG_OUT)
    else $error("interrupt low without flag");
  AST_FLAG_STICKY: assert property (ALARM_MATCH_FLAG_OUT && !ALARM_FLAG_CLEAR_IN |=> ALARM_MATCH_FLAG_OUT)
    else $error("flag dropped without clear");
  AST_MONTH_UNUSED: assert property (REG_READ_IN && REG_ADDR_IN == 8'h0d |=> REG_RDATA_OUT[7:5] == 3'h0)
    else $error("month unused bits not zero");
  AST_YEAR_UNUSED: assert property (REG_READ_IN && REG_ADDR_IN == 8'h0e |=> !REG_RDATA_OUT[7])
    else $error("year unused bit not zero");
  AST_MONTH_LENGTH: assert property (MONTH_LENGTH_OUT inside {6'h28, 6'h29, 6'h30, 6'h31})
    else $error("month length out of set");
  cover property ($rose(ALARM_MATCH_FLAG_OUT));
  cover property ($fell(ALARM_MATCH_FLAG_OUT));
  cover property (MONTH_LENGTH_OUT == 6'h29);
endmodule // calam_monitor

// ==== tb/calam_host_model.sv ====
// Host processor model driving the register port
`timescale 1ns/1ps
module calam_host_model (
  input  wire logic       clock_in,
  input  wire logic [7:0] rdata_in,
  output logic      [7:0] addr_out = 8'h00,
  output logic      [7:0] wdata_out = 8'h00,
  output logic            write_out = 1'b0,
  output logic            read_out = 1'b0
);
  // Callers may hand over BCD codes with stray bits above the field, such as 92 to the month
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock_in);
    addr_out = a;
    wdata_out = d;
    write_out = 1'b1;
    @(negedge clock_in);
    write_out = 1'b0;
    wdata_out = ~d; // Idle bus never keeps stale data
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clock_in);
    addr_out = a;
    read_out = 1'b1;
    @(negedge clock_in);
    read_out = 1'b0;
    d = rdata_in;
  endtask
endmodule // calam_host_model

// ==== tb/calam_calendar_alarm_match_tb.sv ====
// Self-checking bench for the calendar and alarm match block
`timescale 1ns/1ps
module calam_calendar_alarm_match_tb;
  logic       clk = 1'b0, rst = 1'b1, adv = 1'b0, irq_en = 1'b1, clr = 1'b0;
  logic [7:0] addr, wdata, rdata, got;
  logic       write, read, flag, int_n;
  logic [6:0] now_s = 7'h00, now_m = 7'h12;
  logic [5:0] now_h = 6'h04, mlen;
  logic [2:0] now_w = 3'h1;
  logic [23:0] tab [6] = '{24'h020029, 24'h022328, 24'h021028, 24'h022429, 24'h041230, 24'h127931};
  int         fails = 0, compares = 0, cyc = 0;
  initial forever #5 clk = ~clk;
  calam_host_model host (.clock_in(clk), .rdata_in(rdata), .addr_out(addr), .wdata_out(wdata),
    .write_out(write), .read_out(read));
  calam_calendar_alarm_match uut (.CLOCK_IN(clk), .RESET_IN(rst), .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata),
    .REG_WRITE_IN(write), .REG_READ_IN(read), .REG_RDATA_OUT(rdata), .NOW_SECONDS_IN(now_s),
    .NOW_MINUTES_IN(now_m), .NOW_HOURS_IN(now_h), .NOW_DAY_IN(6'h01), .NOW_WEEKDAY_IN(now_w),
    .MONTH_ADVANCE_IN(adv), .ALARM_IRQ_ENABLE_IN(irq_en), .ALARM_FLAG_CLEAR_IN(clr),
    .ALARM_MATCH_FLAG_OUT(flag), .INT_N_OUT(int_n), .MONTH_LENGTH_OUT(mlen));
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e)
    begin
      fails++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    host.rd(a, got);
    chk("register", e, got);
  endtask
  task automatic fchk(input logic [1:0] e);
    chk("flag and interrupt", {6'h00, e}, {6'h00, flag, int_n});
  endtask
  // Leaves the seconds match and enters it again, so each call where the other enabled fields match is a fresh match entry
  task automatic enter(input logic [1:0] e);
    @(negedge clk) now_s = 7'h29;
    @(negedge clk) now_s = 7'h30;
    repeat (2) @(negedge clk);
    fchk(e);
  endtask
  task automatic tally_and_finish();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      fails++;
      tally_and_finish();
    end
  end
  initial
  begin
    repeat (16) @(negedge clk);
    rst = 1'b0;
    rchk(8'h0d, 8'h01);
    rchk(8'h0e, 8'h00);
    host.wr(8'h0d, 8'h92);
    rchk(8'h0d, 8'h12);
    host.wr(8'h0e, 8'hd9);
    rchk(8'h0e, 8'h59);
    host.wr(8'h10, 8'hb0);
    rchk(8'h10, 8'hb0);
    host.wr(8'h11, 8'h45);
    rchk(8'h11, 8'h45);
    host.wr(8'h12, 8'h84);
    rchk(8'h12, 8'h84);
    rchk(8'h0f, 8'h00);
    $display("test registers done");
    enter(2'b10);
    repeat (4) @(negedge clk);
    fchk(2'b10);
    @(negedge clk) clr = 1'b1;
    @(negedge clk) clr = 1'b0;
    repeat (4) @(negedge clk);
    fchk(2'b01);
    now_h = 6'h05;
    enter(2'b01);
    now_h = 6'h04;
    irq_en = 1'b0;
    enter(2'b01);
    irq_en = 1'b1;
    repeat (3) @(negedge clk);
    fchk(2'b01);
    host.wr(8'h14, 8'h83);
    enter(2'b01);
    now_w = 3'h3;
    enter(2'b10);
    $display("test alarm done");
    foreach (tab[i])
    begin
      host.wr(8'h0d, tab[i][23:16]);
      host.wr(8'h0e, tab[i][15:8]);
      repeat (2) @(negedge clk);
      chk("month length", tab[i][7:0], {2'b00, mlen});
    end
    @(negedge clk) adv = 1'b1;
    @(negedge clk) adv = 1'b0;
    rchk(8'h0d, 8'h01);
    rchk(8'h0e, 8'h00);
    $display("test calendar done");
    tally_and_finish();
  end
endmodule // calam_calendar_alarm_match_tb
bind calam_calendar_alarm_match calam_monitor mon (.CLOCK_IN, .RESET_IN, .REG_ADDR_IN, .REG_READ_IN,
  .REG_RDATA_OUT, .ALARM_IRQ_ENABLE_IN, .ALARM_FLAG_CLEAR_IN, .ALARM_MATCH_FLAG_OUT, .INT_N_OUT,
  .MONTH_LENGTH_OUT);
